/* File: afr_params.svh */
/*
  Holds the register offsets, field positions, reset values and pin indices of the remap mux.
  Assumes it is included by its bare name from the remap mux package and modules.
*/
`ifndef AFR_PARAMS_SVH
`define AFR_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AFR_OFF_OPTIONS    12'h000
`define AFR_OFF_ACTIVE     12'h004
`define AFR_OFF_PINSEL     12'h008
`define AFR_OFF_STATUS     12'h00c

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AFR_OPTIONS_RESET  8'h00
`define AFR_PINSEL_RESET   8'h00

// ----------------------------------------
// Option bit positions
// ----------------------------------------
`define AFR_BIT_ZERO       0
`define AFR_BIT_ONE        1
`define AFR_BIT_TWO        2
`define AFR_BIT_THREE      3
`define AFR_BIT_FOUR       4
`define AFR_BIT_FIVE       5
`define AFR_BIT_SIX        6
`define AFR_BIT_SEVEN      7

// ----------------------------------------
// Pin indices
// ----------------------------------------
`define AFR_PIN_A3         0
`define AFR_PIN_B4         1
`define AFR_PIN_B5         2
`define AFR_PIN_C3         3
`define AFR_PIN_C4         4
`define AFR_PIN_C5         5
`define AFR_PIN_C6         6
`define AFR_PIN_C7         7
`define AFR_PIN_D0         8
`define AFR_PIN_D2         9
`define AFR_PIN_D4         10
`define AFR_PIN_D7         11
`define AFR_NUM_PINS       12

// ----------------------------------------
// Status bits
// ----------------------------------------
`define AFR_ST_CONFLICT    0
`define AFR_ST_FORBIDDEN   1

`endif

/* File: afr_pkg.sv */
/*
  Holds the types shared by the remap mux modules.
  Assumes afr_params.svh is on the include path.
*/
`include "afr_params.svh"

package afr_pkg;
  typedef logic [7:0]                    afr_opt_t;
  typedef logic [`AFR_NUM_PINS-1:0]      afr_pins_t;
endpackage

/* File: afr_pad_mux.sv */
/*
  Holds one pad cell multiplexer: selects GPIO or alternate function per pin.
  Assumes the alternate routing is already resolved by the remap mux.
*/
`include "afr_params.svh"

module afr_pad_mux #(
  parameter int NUM_PINS = `AFR_NUM_PINS
) (
  input  wire logic [NUM_PINS-1:0] gpio_out,
  input  wire logic [NUM_PINS-1:0] gpio_oe,
  input  wire logic [NUM_PINS-1:0] alt_out,
  input  wire logic [NUM_PINS-1:0] alt_oe,
  input  wire logic [NUM_PINS-1:0] alt_sel,
  output logic      [NUM_PINS-1:0] pad_out,
  output logic      [NUM_PINS-1:0] pad_oe
);
  import afr_pkg::*;

  if (NUM_PINS < 1) begin : g_bad_size
    $error("NUM_PINS must be positive");
  end

  // ----------------------------------------
  // Per pin selection
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      assign pad_out[gi] = alt_sel[gi] ? alt_out[gi] : gpio_out[gi];
      assign pad_oe[gi]  = alt_sel[gi] ? alt_oe[gi]  : gpio_oe[gi];
    end
  endgenerate
endmodule

/* File: afr_remap_mux.sv */
/*
  Holds the alternate-function remap multiplexer with an APB register slave.
  Assumes a single 250 MHz pclk, active low asynchronous presetn and asynchronous pad inputs.
*/
`include "afr_params.svh"

module afr_remap_mux (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  adv_timer_inv_chan1,
  input  wire logic                  adv_timer_inv_chan2,
  input  wire logic                  adv_timer_chan1,
  input  wire logic                  adv_timer_chan2,
  input  wire logic                  adv_timer_chan3,
  input  wire logic                  adv_timer_chan4,
  input  wire logic                  gp_timer_chan1,
  input  wire logic                  gp_timer_chan3,
  input  wire logic                  config_clock_out,
  input  wire logic                  uart_sync_clock,
  input  wire logic                  uart_transmit,
  input  wire logic                  spi_slave_select,
  input  wire logic                  spi_clock,
  input  wire logic                  spi_mosi,
  input  wire logic                  spi_miso,
  input  wire logic                  i2c_clock,
  input  wire logic                  i2c_data,
  input  wire logic                  tone_output,
  output logic                       adv_timer_break_in,
  output logic                       converter_ext_trigger,
  output logic                       top_level_irq_in,
  output logic                       analog_in_two,
  output logic                       analog_in_three,
  output logic                       tone_on_pin,
  input  wire afr_pkg::afr_pins_t    gpio_out,
  input  wire afr_pkg::afr_pins_t    gpio_oe,
  input  wire afr_pkg::afr_pins_t    pad_in,
  output afr_pkg::afr_pins_t         pad_out,
  output afr_pkg::afr_pins_t         pad_oe
);
  import afr_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  afr_opt_t  pin_remap_options_reg = `AFR_OPTIONS_RESET;
  afr_opt_t  active_opt_reg;
  logic      latch_done_reg;
  afr_opt_t  pinsel_reg;
  afr_pins_t pad_sync1_reg;
  afr_pins_t pad_sync2_reg;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire       acc_phase  = psel && penable;
  wire       hit_opt    = (paddr == `AFR_OFF_OPTIONS);
  wire       hit_act    = (paddr == `AFR_OFF_ACTIVE);
  wire       hit_sel    = (paddr == `AFR_OFF_PINSEL);
  wire       hit_st     = (paddr == `AFR_OFF_STATUS);
  wire       hit_any    = hit_opt || hit_act || hit_sel || hit_st;
  wire       wr_opt     = acc_phase && pwrite && hit_opt;
  wire       wr_sel     = acc_phase && pwrite && hit_sel;
  wire       bad_write  = pwrite && (hit_act || hit_st);

  // ----------------------------------------
  // Active option decode
  // ----------------------------------------
  wire o0 = active_opt_reg[`AFR_BIT_ZERO];
  wire o1 = active_opt_reg[`AFR_BIT_ONE];
  wire o2 = active_opt_reg[`AFR_BIT_TWO];
  wire o3 = active_opt_reg[`AFR_BIT_THREE];
  wire o4 = active_opt_reg[`AFR_BIT_FOUR];
  wire o5 = active_opt_reg[`AFR_BIT_FIVE];
  wire o6 = active_opt_reg[`AFR_BIT_SIX];
  wire o7 = active_opt_reg[`AFR_BIT_SEVEN];

  wire a3_uart  = o1 && o0;
  wire a3_spi   = o1 && !o0;
  wire c3_inv   = o7;
  wire c3_irq   = o3 && !o7;
  wire c4_inv   = o7;
  wire c4_ain   = o2 && !o7;
  wire forbid   = o1 && o0;
  wire conflict = (o7 && o3) || (o7 && o2);
  wire [7:0] status_w = {6'h00, forbid, conflict};

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  wire [31:0] rd_w = hit_opt ? {24'h000000, pin_remap_options_reg} :
                     hit_act ? {24'h000000, active_opt_reg} :
                     hit_sel ? {24'h000000, pinsel_reg} :
                     hit_st  ? {24'h000000, status_w} : 32'h00000000;

  assign pready  = 1'b1;
  assign pslverr = acc_phase && (!hit_any || bad_write);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_w;
    end
  end

  // ----------------------------------------
  // Option storage and reset latch
  // ----------------------------------------
  // Non-volatile option bits, kept across presetn
  always_ff @(posedge pclk) begin
    if (wr_opt) begin
      pin_remap_options_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_opt_reg <= `AFR_OPTIONS_RESET;
      latch_done_reg <= 1'b0;
    end else if (!latch_done_reg) begin
      active_opt_reg <= pin_remap_options_reg;
      latch_done_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Peripheral pin select
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pinsel_reg <= `AFR_PINSEL_RESET;
    end else if (wr_sel) begin
      pinsel_reg <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // Pad input synchroniser
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_sync1_reg <= '0;
      pad_sync2_reg <= '0;
    end else begin
      pad_sync1_reg <= pad_in;
      pad_sync2_reg <= pad_sync1_reg;
    end
  end

  // ----------------------------------------
  // Output routing per pin
  // ----------------------------------------
  afr_pins_t alt_out;
  afr_pins_t alt_oe;
  afr_pins_t alt_sel;

  assign alt_out[`AFR_PIN_A3] = a3_uart ? uart_transmit : a3_spi ? spi_slave_select : gp_timer_chan3;
  assign alt_oe[`AFR_PIN_A3]  = 1'b1;
  assign alt_out[`AFR_PIN_B4] = i2c_clock;
  assign alt_oe[`AFR_PIN_B4]  = !o4;
  assign alt_out[`AFR_PIN_B5] = i2c_data;
  assign alt_oe[`AFR_PIN_B5]  = !o4;
  assign alt_out[`AFR_PIN_C3] = c3_inv ? adv_timer_inv_chan1 : adv_timer_chan3;
  assign alt_oe[`AFR_PIN_C3]  = !c3_irq;
  assign alt_out[`AFR_PIN_C4] = c4_inv ? adv_timer_inv_chan2 : adv_timer_chan4;
  assign alt_oe[`AFR_PIN_C4]  = !c4_ain;
  assign alt_out[`AFR_PIN_C5] = o0 ? gp_timer_chan1 : spi_clock;
  assign alt_oe[`AFR_PIN_C5]  = 1'b1;
  assign alt_out[`AFR_PIN_C6] = o0 ? adv_timer_chan1 : spi_mosi;
  assign alt_oe[`AFR_PIN_C6]  = 1'b1;
  assign alt_out[`AFR_PIN_C7] = o0 ? adv_timer_chan2 : spi_miso;
  assign alt_oe[`AFR_PIN_C7]  = 1'b1;
  assign alt_out[`AFR_PIN_D0] = config_clock_out;
  assign alt_oe[`AFR_PIN_D0]  = o5;
  assign alt_out[`AFR_PIN_D2] = 1'b0;
  assign alt_oe[`AFR_PIN_D2]  = 1'b0;
  assign alt_out[`AFR_PIN_D4] = uart_sync_clock;
  assign alt_oe[`AFR_PIN_D4]  = o2;
  assign alt_out[`AFR_PIN_D7] = adv_timer_chan4;
  assign alt_oe[`AFR_PIN_D7]  = o6;

  // Pin group selected by a peripheral enable; remap-only pins need their option too
  wire [7:0] ps = pinsel_reg;
  assign alt_sel[`AFR_PIN_A3] = ps[0];
  assign alt_sel[`AFR_PIN_B4] = ps[1];
  assign alt_sel[`AFR_PIN_B5] = ps[1];
  assign alt_sel[`AFR_PIN_C3] = ps[2];
  assign alt_sel[`AFR_PIN_C4] = ps[2];
  assign alt_sel[`AFR_PIN_C5] = ps[3];
  assign alt_sel[`AFR_PIN_C6] = ps[3];
  assign alt_sel[`AFR_PIN_C7] = ps[3];
  assign alt_sel[`AFR_PIN_D0] = ps[4] && o5;
  assign alt_sel[`AFR_PIN_D2] = ps[5] && o2;
  assign alt_sel[`AFR_PIN_D4] = ps[5] && o2;
  assign alt_sel[`AFR_PIN_D7] = ps[6] && o6;

  // ----------------------------------------
  // Input routing
  // ----------------------------------------
  assign converter_ext_trigger = o4 && alt_sel[`AFR_PIN_B4] && pad_sync2_reg[`AFR_PIN_B4];
  assign adv_timer_break_in    = o4 && alt_sel[`AFR_PIN_B5] && pad_sync2_reg[`AFR_PIN_B5];
  assign top_level_irq_in      = c3_irq && alt_sel[`AFR_PIN_C3] && pad_sync2_reg[`AFR_PIN_C3];
  assign analog_in_two         = c4_ain && alt_sel[`AFR_PIN_C4] && pad_sync2_reg[`AFR_PIN_C4];
  assign analog_in_three       = alt_sel[`AFR_PIN_D2] && pad_sync2_reg[`AFR_PIN_D2];
  assign tone_on_pin           = o7 && ps[7] && tone_output;

  // ----------------------------------------
  // Pad cells
  // ----------------------------------------
  afr_pad_mux #(
    .NUM_PINS (`AFR_NUM_PINS)
  ) u_pad (
    .gpio_out (gpio_out),
    .gpio_oe  (gpio_oe),
    .alt_out  (alt_out),
    .alt_oe   (alt_oe),
    .alt_sel  (alt_sel),
    .pad_out  (pad_out),
    .pad_oe   (pad_oe)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_INV_C3: assert property (@(posedge pclk) disable iff (!presetn)
    (o7 && ps[2]) |-> (pad_out[`AFR_PIN_C3] == adv_timer_inv_chan1 && pad_oe[`AFR_PIN_C3]))
    else $error("C3 not carrying inverted channel 1");
  AST_DEFAULT_C5: assert property (@(posedge pclk) disable iff (!presetn)
    (!o0 && ps[3]) |-> (pad_out[`AFR_PIN_C5] == spi_clock))
    else $error("C5 not on default SPI clock");
  AST_D7_CH4: assert property (@(posedge pclk) disable iff (!presetn)
    (o6 && ps[6]) |-> (pad_out[`AFR_PIN_D7] == adv_timer_chan4 && pad_oe[`AFR_PIN_D7]))
    else $error("D7 not carrying channel 4");
  AST_D0_CLK: assert property (@(posedge pclk) disable iff (!presetn)
    (!o5) |-> (pad_out[`AFR_PIN_D0] == gpio_out[`AFR_PIN_D0]))
    else $error("D0 remapped without option five");
  AST_B4_TRIG: assert property (@(posedge pclk) disable iff (!presetn)
    (o4 && ps[1] && $past(pad_in[`AFR_PIN_B4], 2) && $stable(ps) && $stable(active_opt_reg)) |-> converter_ext_trigger)
    else $error("Trigger not taken from B4");
  AST_TLI: assert property (@(posedge pclk) disable iff (!presetn)
    (!o3) |-> !top_level_irq_in)
    else $error("Interrupt input active without option three");
  AST_TONE: assert property (@(posedge pclk) disable iff (!presetn)
    tone_on_pin |-> (o7 && tone_output))
    else $error("Tone output without option seven");
  AST_A3_SPI: assert property (@(posedge pclk) disable iff (!presetn)
    (o1 && !o0 && ps[0]) |-> (pad_out[`AFR_PIN_A3] == spi_slave_select))
    else $error("A3 not carrying SPI select");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    latch_done_reg |=> $stable(active_opt_reg))
    else $error("Active options changed after latch");
  AST_RESET_GPIO: assert property (@(posedge pclk) disable iff (!presetn)
    (pinsel_reg == 8'h00) |-> (pad_out == gpio_out && pad_oe == gpio_oe))
    else $error("Pin left GPIO control with no select");
  AST_INV_C4: assert property (@(posedge pclk) disable iff (!presetn)
    (o7 && ps[2]) |-> (pad_out[`AFR_PIN_C4] == adv_timer_inv_chan2 && pad_oe[`AFR_PIN_C4]))
    else $error("C4 not carrying inverted channel 2");
  AST_DEFAULT_A3: assert property (@(posedge pclk) disable iff (!presetn)
    (!o1 && ps[0]) |-> (pad_out[`AFR_PIN_A3] == gp_timer_chan3))
    else $error("A3 not on default channel");
  AST_DEFAULT_B45: assert property (@(posedge pclk) disable iff (!presetn)
    (!o4 && ps[1]) |-> (pad_out[`AFR_PIN_B4] == i2c_clock && pad_out[`AFR_PIN_B5] == i2c_data))
    else $error("B4 or B5 not on default function");
  AST_DEFAULT_C3: assert property (@(posedge pclk) disable iff (!presetn)
    (!o7 && !o3 && ps[2]) |-> (pad_out[`AFR_PIN_C3] == adv_timer_chan3 && pad_oe[`AFR_PIN_C3]))
    else $error("C3 not on default channel");
  AST_DEFAULT_C4: assert property (@(posedge pclk) disable iff (!presetn)
    (!o7 && !o2 && ps[2]) |-> (pad_out[`AFR_PIN_C4] == adv_timer_chan4 && pad_oe[`AFR_PIN_C4]))
    else $error("C4 not on default channel");
  AST_D7_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (!o6) |-> (pad_out[`AFR_PIN_D7] == gpio_out[`AFR_PIN_D7]))
    else $error("D7 remapped without option six");
  AST_D24_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (!o2) |-> (pad_out[`AFR_PIN_D2] == gpio_out[`AFR_PIN_D2] && pad_out[`AFR_PIN_D4] == gpio_out[`AFR_PIN_D4]))
    else $error("D2 or D4 remapped without option two");
  AST_IN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (!o4) |-> (!converter_ext_trigger && !adv_timer_break_in))
    else $error("Trigger or break input without option four");
  AST_AIN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (!o2) |-> (!analog_in_two && !analog_in_three))
    else $error("Analog input without option two");
  AST_D0_ON: assert property (@(posedge pclk) disable iff (!presetn)
    (o5 && ps[4]) |-> (pad_out[`AFR_PIN_D0] == config_clock_out && pad_oe[`AFR_PIN_D0]))
    else $error("D0 not carrying clock output");
  AST_B5_BREAK: assert property (@(posedge pclk) disable iff (!presetn)
    (o4 && ps[1]) |-> (adv_timer_break_in == $past(pad_in[`AFR_PIN_B5], 2)))
    else $error("Break input not taken from B5");
  AST_B45_IN: assert property (@(posedge pclk) disable iff (!presetn)
    (o4 && ps[1]) |-> (!pad_oe[`AFR_PIN_B4] && !pad_oe[`AFR_PIN_B5]))
    else $error("B4 or B5 driven while remapped to input");
  AST_TLI_ON: assert property (@(posedge pclk) disable iff (!presetn)
    (o3 && !o7 && ps[2]) |-> (top_level_irq_in == $past(pad_in[`AFR_PIN_C3], 2)))
    else $error("Interrupt input not taken from C3");
  AST_C3_IN: assert property (@(posedge pclk) disable iff (!presetn)
    (o3 && !o7 && ps[2]) |-> !pad_oe[`AFR_PIN_C3])
    else $error("C3 driven while used as interrupt input");
  AST_AIN_TWO: assert property (@(posedge pclk) disable iff (!presetn)
    (o2 && !o7 && ps[2]) |-> (analog_in_two == $past(pad_in[`AFR_PIN_C4], 2) && !pad_oe[`AFR_PIN_C4]))
    else $error("Analog input 2 not taken from C4");
  AST_AIN_THREE: assert property (@(posedge pclk) disable iff (!presetn)
    (o2 && ps[5]) |-> (analog_in_three == $past(pad_in[`AFR_PIN_D2], 2) && !pad_oe[`AFR_PIN_D2]))
    else $error("Analog input 3 not taken from D2");
  AST_D4_UART: assert property (@(posedge pclk) disable iff (!presetn)
    (o2 && ps[5]) |-> (pad_out[`AFR_PIN_D4] == uart_sync_clock && pad_oe[`AFR_PIN_D4]))
    else $error("D4 not carrying UART clock");
  AST_TONE_ON: assert property (@(posedge pclk) disable iff (!presetn)
    (o7 && ps[7]) |-> (tone_on_pin == tone_output))
    else $error("Tone output not reaching its pin");
  AST_NO_TONE: assert property (@(posedge pclk) disable iff (!presetn)
    (!ps[7]) |-> !tone_on_pin)
    else $error("Tone output without pin select");
  AST_C5_C7: assert property (@(posedge pclk) disable iff (!presetn)
    (o0 && ps[3]) |-> (pad_out[`AFR_PIN_C5] == gp_timer_chan1 && pad_out[`AFR_PIN_C6] == adv_timer_chan1
      && pad_out[`AFR_PIN_C7] == adv_timer_chan2))
    else $error("C5 to C7 not carrying timer channels");
  AST_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    (presetn && !latch_done_reg) |=> (active_opt_reg == $past(pin_remap_options_reg)))
    else $error("Options not latched at reset release");
endmodule

/* File: afr_periph_model.sv */
/*
  Holds a model of the peripherals and pads around the remap mux: a shifting pattern on every
  peripheral signal and the inverse of its low twelve bits on the pad inputs.
  Assumes a free running pclk and the active low presetn of the bench.
*/
module afr_periph_model (
  input  wire logic               pclk,
  input  wire logic               presetn,
  output logic      [17:0]        periph,
  output afr_pkg::afr_pins_t      pad_in
);
  import afr_pkg::*;
  logic [17:0] pat_reg;
  // ----------------------------------------
  // Pattern source, changes every cycle
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pat_reg <= 18'h00001;
    end else begin
      pat_reg <= {pat_reg[16:0], pat_reg[17] ^ pat_reg[10]};
    end
  end
  assign periph = pat_reg;
  assign pad_in = ~pat_reg[11:0];
endmodule

/* File: tb.sv */
/*
  Holds the self-checking bench of the remap mux: APB register access, reset routing and defaults.
  Assumes afr_params.svh on the include path and afr_periph_model beside the design.
*/
`include "afr_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import afr_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, tone_on_pin, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [17:0] periph;
  logic        brk_in, trig_in, irq_in, ain_two, ain_three;
  afr_pins_t   pin_d1, pin_d2;
  afr_pins_t   gpio_out, gpio_oe, pad_in, pad_out, pad_oe;
  int          n_mismatch, n_compared, cycles;

  afr_periph_model peer (.pclk(pclk), .presetn(presetn), .periph(periph), .pad_in(pad_in));

  afr_remap_mux uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adv_timer_inv_chan1(periph[0]), .adv_timer_inv_chan2(periph[1]), .adv_timer_chan1(periph[2]),
    .adv_timer_chan2(periph[3]), .adv_timer_chan3(periph[4]), .adv_timer_chan4(periph[5]),
    .gp_timer_chan1(periph[6]), .gp_timer_chan3(periph[7]), .config_clock_out(periph[8]),
    .uart_sync_clock(periph[9]), .uart_transmit(periph[10]), .spi_slave_select(periph[11]),
    .spi_clock(periph[12]), .spi_mosi(periph[13]), .spi_miso(periph[14]), .i2c_clock(periph[15]),
    .i2c_data(periph[16]), .tone_output(periph[17]), .adv_timer_break_in(brk_in), .converter_ext_trigger(trig_in),
    .top_level_irq_in(irq_in), .analog_in_two(ain_two), .analog_in_three(ain_three), .tone_on_pin(tone_on_pin),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe)
  );

  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  always #2 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      wrap_up;
    end
  end

  // Two-stage copy of the pad inputs, as seen by the peripherals
  always @(posedge pclk) begin
    pin_d1 <= pad_in;
    pin_d2 <= pin_d1;
  end

  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
    apb(1'b1, a, d);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_state;
    rd_chk(`AFR_OFF_OPTIONS, 32'h0, 1'b0);
    rd_chk(`AFR_OFF_ACTIVE, 32'h0, 1'b0);
    rd_chk(`AFR_OFF_PINSEL, 32'h0, 1'b0);
    @(negedge pclk);
    chk(32'(pad_out), 32'(gpio_out));
    chk(32'(pad_oe), 32'(gpio_oe));
    chk({31'h0, tone_on_pin}, 32'h0);
    @(posedge pclk);
  endtask

  task automatic t_regs;
    wr_chk(`AFR_OFF_OPTIONS, 32'hffff_ff51, 1'b0);
    rd_chk(`AFR_OFF_OPTIONS, 32'h51, 1'b0);
    rd_chk(`AFR_OFF_ACTIVE, 32'h0, 1'b0);
    wr_chk(`AFR_OFF_ACTIVE, 32'hff, 1'b1);
    rd_chk(`AFR_OFF_ACTIVE, 32'h0, 1'b0);
    wr_chk(`AFR_OFF_STATUS, 32'hff, 1'b1);
    rd_chk(12'h010, 32'h0, 1'b1);
  endtask

  task automatic t_routing;
    gpio_out <= ~gpio_out;
    wr_chk(`AFR_OFF_PINSEL, 32'h08, 1'b0);
    rd_chk(`AFR_OFF_PINSEL, 32'h08, 1'b0);
    repeat (6) begin
      @(negedge pclk);
      chk(32'(pad_out[7:5]), 32'(periph[14:12]));
      chk(32'(pad_out[4:0]), 32'(gpio_out[4:0]));
    end
    @(posedge pclk);
    wr_chk(`AFR_OFF_PINSEL, 32'hff, 1'b0);
    repeat (8) begin
      @(negedge pclk);
      chk(32'({pad_out[7:5], pad_out[3], pad_out[0]}), 32'({periph[14:12], periph[4], periph[7]}));
      chk({31'h0, tone_on_pin}, 32'h0);
    end
    @(posedge pclk);
  endtask

  task automatic t_remap_a;
    rd_chk(`AFR_OFF_ACTIVE, 32'h51, 1'b0);
    @(negedge pclk);
    chk(32'(pad_out), 32'(gpio_out));
    @(posedge pclk);
    wr_chk(`AFR_OFF_PINSEL, 32'hff, 1'b0);
    repeat (4) begin
      @(negedge pclk);
      chk(32'(pad_out[7:5]), {29'h0, periph[3:2], periph[6]});
      chk({30'h0, pad_out[11], pad_oe[11]}, {30'h0, periph[5], 1'b1});
      chk({30'h0, pad_oe[2:1]}, 32'h0);
      chk({30'h0, brk_in, trig_in}, {30'h0, pin_d2[2:1]});
    end
    @(posedge pclk);
    wr_chk(`AFR_OFF_OPTIONS, 32'ha2, 1'b0);
  endtask

  task automatic t_remap_b;
    rd_chk(`AFR_OFF_ACTIVE, 32'ha2, 1'b0);
    rd_chk(`AFR_OFF_STATUS, 32'h0, 1'b0);
    wr_chk(`AFR_OFF_PINSEL, 32'hff, 1'b0);
    repeat (4) begin
      @(negedge pclk);
      chk({28'h0, pad_out[4:3], pad_oe[4:3]}, {28'h0, periph[1:0], 2'b11});
      chk({30'h0, pad_out[8], pad_oe[8]}, {30'h0, periph[8], 1'b1});
      chk({31'h0, tone_on_pin}, {31'h0, periph[17]});
      chk({31'h0, pad_out[0]}, {31'h0, periph[11]});
    end
    @(posedge pclk);
    wr_chk(`AFR_OFF_OPTIONS, 32'h04, 1'b0);
  endtask

  task automatic t_remap_c;
    rd_chk(`AFR_OFF_ACTIVE, 32'h04, 1'b0);
    wr_chk(`AFR_OFF_PINSEL, 32'hff, 1'b0);
    repeat (4) begin
      @(negedge pclk);
      chk({29'h0, pad_oe[10:9], pad_oe[4]}, 32'h4);
      chk({30'h0, ain_three, ain_two}, {30'h0, pin_d2[9], pin_d2[4]});
      chk({31'h0, pad_out[10]}, {31'h0, periph[9]});
    end
    @(posedge pclk);
    wr_chk(`AFR_OFF_OPTIONS, 32'h08, 1'b0);
  endtask

  task automatic t_remap_d;
    rd_chk(`AFR_OFF_ACTIVE, 32'h08, 1'b0);
    wr_chk(`AFR_OFF_PINSEL, 32'hff, 1'b0);
    repeat (4) begin
      @(negedge pclk);
      chk({31'h0, pad_oe[3]}, 32'h0);
      chk({31'h0, irq_in}, {31'h0, pin_d2[3]});
    end
    @(posedge pclk);
    wr_chk(`AFR_OFF_OPTIONS, 32'h00, 1'b0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    gpio_out = 12'ha5c;
    gpio_oe = 12'h3c3;
    n_mismatch = 0;
    n_compared = 0;
    cycles = 0;
    do_reset;
    t_reset_state;
    t_regs;
    t_routing;
    do_reset;
    t_remap_a;
    do_reset;
    t_remap_b;
    do_reset;
    t_remap_c;
    do_reset;
    t_remap_d;
    do_reset;
    t_reset_state;
    wrap_up;
  end
endmodule
